// ===== core/sits_pkg.sv
// constants for the safety i/o tag status block
`default_nettype none
package sits_pkg;
	// timing
	localparam int unsigned CLK_HZ  = 20_000_000;
	localparam int unsigned OVF_HZ  = 1000;
	localparam int unsigned UNF_HZ  = 1;
	localparam int unsigned OVF_CYC = CLK_HZ / OVF_HZ;
	localparam int unsigned UNF_CYC = CLK_HZ / UNF_HZ;
	localparam int unsigned TCW     = 25;
	// sizes
	localparam int unsigned N_DIN  = 8;
	localparam int unsigned N_DOUT = 8;
	localparam int unsigned N_TST  = 4;
	localparam int unsigned N_ACH  = 4;
	localparam int unsigned N_SYNC = 43;
	// byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_CMD   = 8'h04;
	localparam logic [7:0] A_TRST  = 8'h08;
	localparam logic [7:0] A_DSTAT = 8'h0C;
	localparam logic [7:0] A_DAUX  = 8'h10;
	localparam logic [7:0] A_ASTAT = 8'h14;
	localparam logic [7:0] A_FRSN  = 8'h18;
	localparam logic [7:0] A_AVAL  = 8'h20;
	localparam logic [7:0] A_LIM   = 8'h40;
	// control field positions
	localparam int unsigned C_RUN  = 0;
	localparam int unsigned C_DUAL = 4;
	localparam int unsigned C_TACH = 8;
	localparam int unsigned C_STDM = 12;
	localparam int unsigned C_LAMP = 16;
	localparam int unsigned C_FALL = 20;
	// lamp terminals
	localparam int unsigned LAMP_A = 0;
	localparam int unsigned LAMP_B = 2;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] CMD_RST  = 32'h0000_0000;
	localparam logic [15:0] HI_RST   = 16'h7FFF;
	localparam logic [15:0] LO_RST   = 16'h8000;
	// axi answers
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;
endpackage : sits_pkg
`default_nettype wire

// ===== core/sits_core.sv
// safety i/o tag status core with axi4-lite register slave
`default_nettype none
module sits_core
	import sits_pkg::*;
#(
	parameter int unsigned OVF_LIM = OVF_CYC,
	parameter int unsigned UNF_LIM = UNF_CYC
)(
	input  wire logic        sys_clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic [7:0]  din_pin_in,
	input  wire logic [7:0]  din_ok_pin_in,
	input  wire logic [7:0]  dout_ok_pin_in,
	input  wire logic [7:0]  rdbk_pin_in,
	input  wire logic [3:0]  test_ok_pin_in,
	input  wire logic        lamp_ok_pin_in,
	input  wire logic        in_pwr_ok_pin_in,
	input  wire logic        out_pwr_ok_pin_in,
	input  wire logic [3:0]  tach_pin_in,
	input  wire logic        conn_ok_in,
	input  wire logic [63:0] ana_val_in,
	input  wire logic [3:0]  ana_ok_in,
	input  wire logic [31:0] ana_rsn_in,
	input  wire logic        ana_pwr_ok_in,
	output logic [7:0]       sout_out,
	output logic [3:0]       tout_out
);

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  st
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (st[b])
			begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// address hits a mapped register
	function automatic logic mapped(input logic [7:0] a);
		logic ok;
		ok = (a <= A_FRSN) || ((a >= A_AVAL) && (a < A_AVAL + 8'h10));
		ok = ok || ((a >= A_LIM) && (a < A_LIM + 8'h40));
		return ok && (a[1:0] == 2'h0);
	endfunction : mapped

	// pin synchroniser stages
	logic [N_SYNC-1:0] s1_q;       // first stage, read only by s2
	logic [N_SYNC-1:0] s2_q;       // safe copy
	logic [N_SYNC-1:0] pins;       // raw bundle

	// software state
	logic [31:0] ctrl_q;           // modes and run flag
	logic [31:0] cmd_q;            // output commands
	logic [15:0] lim_q [N_ACH][4]; // hh, h, l, ll per channel

	// axi write side
	logic        aw_hold_q;        // address captured
	logic [7:0]  awaddr_q;         // captured address
	logic        w_hold_q;         // data captured
	logic [31:0] wdata_q;          // captured data
	logic [3:0]  wstrb_q;          // captured strobes
	logic        bvalid_q;         // response pending
	logic [1:0]  bresp_q;          // response code
	logic        do_wr;            // both halves present

	// axi read side
	logic        rvalid_q;         // read data pending
	logic [31:0] rdata_q;          // read data
	logic [1:0]  rresp_q;          // read response
	logic [31:0] rd_mux;           // combinational read value

	// synchronised field view
	logic [7:0]  din_s;            // input circuits
	logic [7:0]  din_ok_s;         // input circuit health
	logic [7:0]  dout_ok_s;        // output circuit health
	logic [7:0]  rdbk_s;           // 24v sense
	logic [3:0]  test_ok_s;        // test output health
	logic        lamp_ok_s;        // lamp health
	logic        in_pwr_ok_s;      // input field power
	logic        out_pwr_ok_s;     // output field power
	logic [3:0]  tach_s;           // tach levels
	logic [3:0]  tach_d1_q;        // previous tach level

	// status words
	logic [31:0] dstat;            // digital status
	logic [31:0] daux;             // readback and test status
	logic [31:0] astat;            // analog status
	logic        run;              // run state
	logic        conn_flt;         // connection fault

	// tachometer state
	logic [TCW-1:0] tcnt_q [N_ACH]; // cycles since last edge
	logic [3:0]  seen_q;           // one edge seen, period valid
	logic [3:0]  ovf_q;            // latched overfrequency
	logic [3:0]  unf_q;            // underfrequency
	logic [3:0]  tedge;            // trigger edge this cycle
	logic [3:0]  tclr;             // tach reset pulse
	logic [1:0]  dlow;             // dual low per pair

	// analog alarm views
	logic [3:0]  a_proc;           // process alarm status
	logic [3:0]  a_hh;             // high high normal
	logic [3:0]  a_h;              // high normal
	logic [3:0]  a_l;              // low normal
	logic [3:0]  a_ll;             // low low normal

	// bundle the pins so one synchroniser covers them all
	assign pins = {tach_pin_in, out_pwr_ok_pin_in, in_pwr_ok_pin_in,
		lamp_ok_pin_in, test_ok_pin_in, rdbk_pin_in, dout_ok_pin_in,
		din_ok_pin_in, din_pin_in};

	// two-flop synchroniser for every field pin
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			s1_q <= '0;
			s2_q <= '0;
		end
		else
		begin
			s1_q <= pins;
			s2_q <= s1_q;
		end
	end

	// unpack the safe copy
	assign din_s        = s2_q[7:0];
	assign din_ok_s     = s2_q[15:8];
	assign dout_ok_s    = s2_q[23:16];
	assign rdbk_s       = s2_q[31:24];
	assign test_ok_s    = s2_q[35:32];
	assign lamp_ok_s    = s2_q[36];
	assign in_pwr_ok_s  = s2_q[37];
	assign out_pwr_ok_s = s2_q[38];
	assign tach_s       = s2_q[42:39];

	// connection state; conn_ok_in is same-clock logic
	assign run      = ctrl_q[C_RUN];
	assign conn_flt = ~conn_ok_in;

	// digital status word
	always_comb
	begin
		dstat        = '0;
		dstat[7:0]   = din_s;
		dstat[15:8]  = din_ok_s;
		dstat[23:16] = dout_ok_s;
		dstat[24]    = &din_ok_s;
		dstat[25]    = &dout_ok_s;
		// lamp fault only counts while lamp mode is on
		dstat[26]    = ~ctrl_q[C_LAMP] | lamp_ok_s;
		dstat[27]    = ~in_pwr_ok_s;
		dstat[28]    = ~out_pwr_ok_s;
		dstat[29]    = run;
		dstat[30]    = conn_flt;
	end

	// readback and test output status
	always_comb
	begin
		daux       = '0;
		daux[7:0]  = rdbk_s;
		daux[11:8] = test_ok_s;
	end

	// analog alarm compares, signed engineering units
	always_comb
	begin
		for (int c = 0; c < N_ACH; c++)
		begin
			logic signed [15:0] v;
			v = $signed(ana_val_in[16*c +: 16]);
			a_hh[c] = v < $signed(lim_q[c][0]);
			a_h[c]  = v < $signed(lim_q[c][1]);
			a_l[c]  = v > $signed(lim_q[c][2]);
			a_ll[c] = v > $signed(lim_q[c][3]);
			a_proc[c] = a_h[c] & a_l[c];
		end
	end

	// dual low, fixed pairs 0-1 and 2-3
	always_comb
	begin
		for (int p = 0; p < 2; p++)
		begin
			// both sensors low at once means a short
			dlow[p] = ctrl_q[C_DUAL + p] & ~tach_s[2*p] & ~tach_s[2*p+1];
		end
	end

	// analog status word
	always_comb
	begin
		astat        = '0;
		astat[3:0]   = a_proc;
		astat[7:4]   = a_hh;
		astat[11:8]  = a_h;
		astat[15:12] = a_l;
		astat[19:16] = a_ll;
		astat[23:20] = ~ovf_q;
		astat[27:24] = ~unf_q;
		astat[29:28] = ~dlow;
		astat[30]    = ana_pwr_ok_in;
		astat[31]    = 1'b0;
	end

	// trigger edge per channel, polarity from control
	always_comb
	begin
		for (int c = 0; c < N_ACH; c++)
		begin
			if (ctrl_q[C_FALL + c])
			begin
				tedge[c] = tach_d1_q[c] & ~tach_s[c];
			end
			else
			begin
				tedge[c] = ~tach_d1_q[c] & tach_s[c];
			end
		end
	end

	// tach reset: write of ones, zeros do nothing
	assign tclr = (do_wr && awaddr_q == A_TRST && wstrb_q[0])
		? wdata_q[3:0] : 4'h0;

	// tachometer period measurement
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			tach_d1_q <= '0;
			seen_q    <= '0;
			ovf_q     <= '0;
			unf_q     <= '0;
			for (int c = 0; c < N_ACH; c++)
			begin
				tcnt_q[c] <= '0;
			end
		end
		else
		begin
			tach_d1_q <= tach_s;
			for (int c = 0; c < N_ACH; c++)
			begin
				if (!ctrl_q[C_TACH + c])
				begin
					// not in tach mode: hold everything idle
					tcnt_q[c] <= '0;
					seen_q[c] <= 1'b0;
					ovf_q[c]  <= 1'b0;
					unf_q[c]  <= 1'b0;
				end
				else if (tedge[c] && seen_q[c] && !ovf_q[c]
					&& tcnt_q[c] < TCW'(OVF_LIM))
				begin
					// period too short; set beats a same-cycle reset
					ovf_q[c] <= 1'b1;
					tcnt_q[c] <= '0;
				end
				else if (tclr[c])
				begin
					// restart the calculation from scratch
					ovf_q[c]  <= 1'b0;
					seen_q[c] <= 1'b0;
					tcnt_q[c] <= '0;
				end
				else if (ovf_q[c])
				begin
					// latched: calculation frozen until reset
					tcnt_q[c] <= '0;
				end
				else if (tedge[c])
				begin
					seen_q[c] <= 1'b1;
					unf_q[c]  <= 1'b0;
					tcnt_q[c] <= '0;
				end
				else if (tcnt_q[c] >= TCW'(UNF_LIM))
				begin
					// no edge for a full slow period
					unf_q[c] <= 1'b1;
				end
				else
				begin
					tcnt_q[c] <= tcnt_q[c] + 1'b1;
				end
			end
		end
	end

	// outputs: commands gated by run and a healthy connection
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			sout_out <= '0;
			tout_out <= '0;
		end
		else
		begin
			// idle or faulted link forces safe off
			sout_out <= (run && !conn_flt) ? cmd_q[7:0] : 8'h00;
			for (int t = 0; t < N_TST; t++)
			begin
				if (ctrl_q[C_STDM + t])
				begin
					tout_out[t] <= run && !conn_flt && cmd_q[8 + t];
				end
				else if (t == LAMP_A || t == LAMP_B)
				begin
					tout_out[t] <= ctrl_q[C_LAMP];
				end
				else
				begin
					tout_out[t] <= 1'b0;
				end
			end
		end
	end

	// axi write channel handshakes
	assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
	assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
	assign do_wr = aw_hold_q && w_hold_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out  = bresp_q;

	// capture address and data in either order
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= '0;
			w_hold_q  <= 1'b0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OK;
		end
		else
		begin
			if (s_axi_awvalid_in && s_axi_awready_out)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_in;
			end
			if (s_axi_wvalid_in && s_axi_wready_out)
			begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata_in;
				wstrb_q  <= s_axi_wstrb_in;
			end
			if (do_wr)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= mapped(awaddr_q) ? RESP_OK : RESP_DEC;
			end
			else if (bvalid_q && s_axi_bready_in)
			begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// software registers; status words ignore writes
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_q <= CTRL_RST;
			cmd_q  <= CMD_RST;
			for (int c = 0; c < N_ACH; c++)
			begin
				lim_q[c][0] <= HI_RST;
				lim_q[c][1] <= HI_RST;
				lim_q[c][2] <= LO_RST;
				lim_q[c][3] <= LO_RST;
			end
		end
		else if (do_wr)
		begin
			if (awaddr_q == A_CTRL)
			begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end
			else if (awaddr_q == A_CMD)
			begin
				cmd_q <= merge(cmd_q, wdata_q, wstrb_q);
			end
			else if (awaddr_q[7:6] == A_LIM[7:6] && awaddr_q[1:0] == 2'h0)
			begin
				// limits only use the low half
				lim_q[awaddr_q[5:4]][awaddr_q[3:2]] <= 16'(merge(
					{16'h0000, lim_q[awaddr_q[5:4]][awaddr_q[3:2]]},
					wdata_q, wstrb_q));
			end
		end
	end

	// read decode
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (s_axi_araddr_in == A_CTRL)
		begin
			rd_mux = ctrl_q;
		end
		else if (s_axi_araddr_in == A_CMD)
		begin
			rd_mux = cmd_q;
		end
		else if (s_axi_araddr_in == A_DSTAT)
		begin
			rd_mux = dstat;
		end
		else if (s_axi_araddr_in == A_DAUX)
		begin
			rd_mux = daux;
		end
		else if (s_axi_araddr_in == A_ASTAT)
		begin
			rd_mux = astat;
		end
		else if (s_axi_araddr_in == A_FRSN)
		begin
			rd_mux = ana_rsn_in;
		end
		else if (s_axi_araddr_in[7:4] == A_AVAL[7:4])
		begin
			// analog value, health in bit 16
			rd_mux = {15'h0000, ana_ok_in[s_axi_araddr_in[3:2]],
				ana_val_in[16*s_axi_araddr_in[3:2] +: 16]};
		end
		else if (s_axi_araddr_in[7:6] == A_LIM[7:6])
		begin
			rd_mux = {16'h0000, lim_q[s_axi_araddr_in[5:4]][s_axi_araddr_in[3:2]]};
		end
	end

	// axi read channel
	assign s_axi_arready_out = !rvalid_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;

	// one read in flight; data held until taken
	always_ff @(posedge sys_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OK;
		end
		else if (s_axi_arvalid_in && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			// unmapped reads return zero with decode error
			rdata_q  <= mapped(s_axi_araddr_in) ? rd_mux : 32'h0000_0000;
			rresp_q  <= mapped(s_axi_araddr_in) ? RESP_OK : RESP_DEC;
		end
		else if (rvalid_q && s_axi_rready_in)
		begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : sits_core
`default_nettype wire

// ===== verif/sits_core_chk.sv
// port assertions for the tag status core
`default_nettype none
module sits_core_chk
	import sits_pkg::*;
#(
	parameter int unsigned OVF_LIM = OVF_CYC,
	parameter int unsigned UNF_LIM = UNF_CYC
)(
	input wire logic        sys_clk_in,
	input wire logic        sys_rst_in,
	input wire logic        s_axi_bvalid_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        conn_ok_in,
	input wire logic [63:0] ana_val_in,
	input wire logic [3:0]  ana_ok_in,
	input wire logic [31:0] ana_rsn_in,
	input wire logic        ana_pwr_ok_in,
	input wire logic [7:0]  sout_out,
	input wire logic [3:0]  tout_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// read request taken at this edge
	wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
	logic [16:0] ch0_q; // channel 0 ok and value seen at the last edge
	// copy of channel 0 so the read can be tied to its cause
	always_ff @(posedge sys_clk_in)
		ch0_q <= {ana_ok_in[0], ana_val_in[15:0]};
	a_rd_latency: assert property (ar_take |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_rd_stand: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
		else $error("read answer dropped");
	a_wr_stand: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer dropped");
	a_conn_flag: assert property (ar_take && s_axi_araddr_in == A_DSTAT |=>
		s_axi_rdata_out[30] == !$past(conn_ok_in)) else $error("connection flag wrong");
	a_comb_status: assert property (ar_take && s_axi_araddr_in == A_DSTAT |=>
		s_axi_rdata_out[24] == &s_axi_rdata_out[15:8] &&
		s_axi_rdata_out[25] == &s_axi_rdata_out[23:16]) else $error("combined status wrong");
	a_ana_value: assert property (ar_take && s_axi_araddr_in == A_AVAL |=>
		s_axi_rdata_out[16:0] == ch0_q) else $error("analog value wrong");
	a_fault_rsn: assert property (ar_take && s_axi_araddr_in == A_FRSN |=>
		s_axi_rdata_out == $past(ana_rsn_in)) else $error("fault reason wrong");
	a_ana_power: assert property (ar_take && s_axi_araddr_in == A_ASTAT |=>
		s_axi_rdata_out[30] == $past(ana_pwr_ok_in)) else $error("analog power wrong");
	a_proc_alarm: assert property (ar_take && s_axi_araddr_in == A_ASTAT |=>
		s_axi_rdata_out[0] == (s_axi_rdata_out[8] && s_axi_rdata_out[12]))
		else $error("process alarm wrong");
	// lamp terminals 0 and 2 follow lamp mode alone outside standard mode, so only 1 and 3 are gated here
	a_out_gate: assert property (!conn_ok_in |=> sout_out == 8'h00 &&
		tout_out[1] == 1'b0 && tout_out[3] == 1'b0)
		else $error("outputs on without connection");
	c_astat: cover property (ar_take && s_axi_araddr_in == A_ASTAT);
	c_decerr: cover property (s_axi_rvalid_out && s_axi_rresp_out == RESP_DEC);
	c_sout: cover property (sout_out != 8'h00);
endmodule : sits_core_chk
bind sits_core sits_core_chk #(.OVF_LIM(OVF_LIM), .UNF_LIM(UNF_LIM)) sits_core_chk_inst (
	.sys_clk_in, .sys_rst_in, .s_axi_bvalid_out, .s_axi_bresp_out, .s_axi_bready_in,
	.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
	.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .conn_ok_in, .ana_val_in,
	.ana_ok_in, .ana_rsn_in, .ana_pwr_ok_in, .sout_out, .tout_out);
`default_nettype wire

// ===== verif/sits_ctl.sv
// axi4-lite master standing in for the safety controller
`default_nettype none
module sits_ctl (
	input  wire logic        sys_clk_in,
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle at time zero
	initial
	begin
		{awaddr_out, wdata_out, araddr_out} = '0;
		{awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = '0;
	end
	// command words and tach reset go out as whole writes
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk_in);
		awaddr_out <= a;
		wdata_out <= d;
		{awvalid_out, wvalid_out, bready_out} <= 3'h7;
		do
		begin
			@(posedge sys_clk_in);
			if (awready_in)
				awvalid_out <= 1'b0;
			if (wready_in)
				wvalid_out <= 1'b0;
		end
		while (!bvalid_in);
		r = bresp_in;
		bready_out <= 1'b0;
	endtask : bus_wr
	// faults are judged from status words, readback is only informative
	task automatic bus_rd(input logic [7:0] a);
		@(posedge sys_clk_in);
		araddr_out <= a;
		{arvalid_out, rready_out} <= 2'h3;
		do
		begin
			@(posedge sys_clk_in);
			if (arready_in)
				arvalid_out <= 1'b0;
		end
		while (!rvalid_in);
		rready_out <= 1'b0;
	endtask : bus_rd
endmodule : sits_ctl
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the tag status core
`default_nettype none
module tb
	import sits_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned UNF_T = 2000; // shortened limits keep the run brief
	typedef struct packed {logic [7:0] a; logic [31:0] e; logic [31:0] m; logic [1:0] r;} sits_exp_t;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic s_axi_rvalid_out, s_axi_rready_in;
	logic [7:0] din_pin_in = '0, din_ok_pin_in = '0, dout_ok_pin_in = '0, rdbk_pin_in = '0;
	logic [3:0] test_ok_pin_in = '0, tach_pin_in = '0, ana_ok_in = '0, tout_out;
	logic lamp_ok_pin_in = 0, in_pwr_ok_pin_in = 0, out_pwr_ok_pin_in = 0, conn_ok_in = 0;
	logic ana_pwr_ok_in = 0;
	logic [63:0] ana_val_in = '0;
	logic [31:0] ana_rsn_in = '0, x, y, seed;
	logic [7:0] sout_out;
	logic [1:0] br; // last write answer
	logic signed [15:0] v;
	logic signed [15:0] av [9] = '{120, 100, 70, 50, 0, -50, -70, -100, -120};
	sits_exp_t exp_q[$], ex; // notes of expected read answers
	int err_total = 0, tests_run = 0, cyc = 0;
	always #25 sys_clk_in = ~sys_clk_in;
	sits_core #(.OVF_LIM(20), .UNF_LIM(UNF_T)) sits_core_inst (.sys_clk_in, .sys_rst_in,
		.s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in, .din_pin_in, .din_ok_pin_in, .dout_ok_pin_in, .rdbk_pin_in,
		.test_ok_pin_in, .lamp_ok_pin_in, .in_pwr_ok_pin_in, .out_pwr_ok_pin_in, .tach_pin_in,
		.conn_ok_in, .ana_val_in, .ana_ok_in, .ana_rsn_in, .ana_pwr_ok_in, .sout_out, .tout_out);
	sits_ctl sits_ctl_inst (.sys_clk_in, .awaddr_out(s_axi_awaddr_in),
		.awvalid_out(s_axi_awvalid_in), .awready_in(s_axi_awready_out),
		.wdata_out(s_axi_wdata_in), .wvalid_out(s_axi_wvalid_in), .wready_in(s_axi_wready_out),
		.bresp_in(s_axi_bresp_out), .bvalid_in(s_axi_bvalid_out), .bready_out(s_axi_bready_in),
		.araddr_out(s_axi_araddr_in), .arvalid_out(s_axi_arvalid_in),
		.arready_in(s_axi_arready_out), .rvalid_in(s_axi_rvalid_out),
		.rready_out(s_axi_rready_in));
	task automatic test_done;
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : tk
	// note the answer, then issue the read
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r = RESP_OK);
		exp_q.push_back('{a, e & m, m, r});
		sits_ctl_inst.bus_rd(a);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sits_ctl_inst.bus_wr(a, d, br);
	endtask : wr
	// pulses on tach channel 0, p cycles from rise to rise
	task automatic tp(input int n, input int p);
		repeat (n)
		begin
			tach_pin_in[0] <= 1'b1;
			tk(2);
			tach_pin_in[0] <= 1'b0;
			tk(p - 2);
		end
	endtask : tp
	// answer watcher: oldest note against each read answer
	always @(posedge sys_clk_in)
		if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			ex = exp_q.pop_front();
			chk($sformatf("rdata %h", ex.a), ex.e, s_axi_rdata_out & ex.m);
			chk("rresp", {30'h0, ex.r}, {30'h0, s_axi_rresp_out});
		end
	// hang guard, far above the expected run length
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			test_done();
		end
	end
	initial
	begin
		seed = $urandom(25384);
		tk(4);
		sys_rst_in <= 1'b0;
		// reset values and an unmapped word
		rd(A_CTRL, 32'h0, 32'hFFFF_FFFF);
		rd(A_CMD, 32'h0, 32'hFFFF_FFFF);
		rd(A_LIM, 32'h7FFF, 32'hFFFF);
		rd(A_LIM + 8'h08, 32'h8000, 32'hFFFF);
		rd(8'h1C, 32'h0, 32'hFFFF_FFFF, RESP_DEC);
		wr(8'h1C, 32'h1);
		chk("bresp", {30'h0, RESP_DEC}, {30'h0, br});
		// digital status under random pins, lamp mode on; first pass all normal
		wr(A_CTRL, 32'h0001_0000);
		for (int i = 0; i < 8; i++)
		begin
			x = (i == 0) ? 32'hFFFF_FFFF : $urandom();
			y = (i == 0) ? 32'hFF : $urandom();
			{din_pin_in, din_ok_pin_in, dout_ok_pin_in, rdbk_pin_in} <= x;
			{test_ok_pin_in, lamp_ok_pin_in, in_pwr_ok_pin_in, out_pwr_ok_pin_in, conn_ok_in} <= y[7:0];
			tk(4);
			x = {1'b0, !conn_ok_in, 1'b0, !out_pwr_ok_pin_in, !in_pwr_ok_pin_in,
				lamp_ok_pin_in, &dout_ok_pin_in, &din_ok_pin_in, dout_ok_pin_in,
				din_ok_pin_in, din_pin_in};
			rd(A_DSTAT, x, 32'h7FFF_FFFF);
			rd(A_DAUX, {20'h0, test_ok_pin_in, rdbk_pin_in}, 32'h0FFF);
		end
		// lamp mode drives both lamp terminals whatever the connection
		chk("lamp", (32'h1 << LAMP_A) | (32'h1 << LAMP_B), {28'h0, tout_out});
		// commands reach the pins only in run with a good connection
		conn_ok_in <= 1'b1;
		wr(A_CTRL, 32'h0000_F001);
		rd(A_DSTAT, 32'h2400_0000, 32'h6400_0000);
		for (int i = 0; i < 4; i++)
		begin
			x = $urandom();
			wr(A_CMD, x);
			tk(2);
			chk("sout", {24'h0, x[7:0]}, {24'h0, sout_out});
			chk("tout", {28'h0, x[11:8]}, {28'h0, tout_out});
		end
		conn_ok_in <= 1'b0;
		tk(2);
		chk("outs", 32'h0, {20'h0, tout_out, sout_out});
		conn_ok_in <= 1'b1;
		wr(A_CTRL, 32'h0000_F000);
		tk(2);
		chk("outs", 32'h0, {20'h0, tout_out, sout_out});
		// channel 0 limits 100, 50, -50, -100, values on and around them
		wr(A_LIM, 32'h0064);
		wr(A_LIM + 8'h04, 32'h0032);
		wr(A_LIM + 8'h08, 32'hFFCE);
		wr(A_LIM + 8'h0C, 32'hFF9C);
		foreach (av[i])
		begin
			v = av[i];
			ana_val_in <= {48'h0, v};
			{ana_ok_in, ana_pwr_ok_in} <= 5'($urandom());
			ana_rsn_in <= $urandom();
			tk(2);
			rd(A_AVAL, {15'h0, ana_ok_in[0], v}, 32'h0001_FFFF);
			x = {1'b0, ana_pwr_ok_in, 13'h0, !(v <= -100), 3'h0, !(v <= -50), 3'h0,
				!(v >= 50), 3'h0, !(v >= 100), 3'h0, !(v >= 50) && !(v <= -50)};
			rd(A_ASTAT, x, 32'h4001_1111);
			rd(A_FRSN, ana_rsn_in, 32'hFFFF_FFFF);
		end
		// tach on channels 0 and 1, dual low on pair 0 only; channel 1 held high
		tach_pin_in <= 4'h2;
		wr(A_CTRL, 32'h0000_0310);
		tp(4, 10);
		rd(A_ASTAT, 32'h0, 32'h0010_0000);
		tp(4, 40);
		wr(A_TRST, 32'h0);
		tp(2, 40);
		rd(A_ASTAT, 32'h0, 32'h0010_0000);
		wr(A_TRST, 32'h1);
		tp(4, 40);
		rd(A_ASTAT, 32'h0110_0000, 32'h0110_0000);
		tk(UNF_T + 100);
		rd(A_ASTAT, 32'h0010_0000, 32'h0110_0000);
		tach_pin_in <= 4'h0;
		tk(4);
		rd(A_ASTAT, 32'h2000_0000, 32'h3000_0000);
		tach_pin_in <= 4'h2;
		tk(4);
		rd(A_ASTAT, 32'h3000_0000, 32'h3000_0000);
		tk(2);
		test_done();
	end
endmodule : tb
`default_nettype wire
